//--- core/seq_pkg.sv
// Purpose: Shared constants and types for the table-indirect sequencer.
// Assumes: One CPU clock domain; opcode fields are the core's own encodings.
// Notes: Register offsets are byte addresses on a 32-bit Wishbone bus.
package seq_pkg;
   localparam logic [6:0] TADDR_LO = 7'h20;
   localparam logic [13:0] SHORT_TOP = 14'h3f7f;
   localparam logic [1:0] ENT_BRANCH = 2'h0;
   localparam logic [1:0] ENT_CALL = 2'h1;
   localparam logic [1:0] ENT_WORD = 2'h2;
   localparam logic [1:0] ENT_PAIR = 2'h3;
   localparam logic [5:0] OP_LONG_BRANCH = 6'h3e;
   localparam logic [5:0] OP_FAR_CALL = 6'h3f;
   localparam logic [3:0] OP_PAIR_MEM = 4'hc;
   localparam logic [3:0] OP_PAIR_STEP = 4'h5;
   localparam logic [1:0] MEM_STORE = 2'h1;
   localparam logic [1:0] MEM_BAD = 2'h3;
   localparam logic [1:0] PTR_HL = 2'h0;
   localparam logic [1:0] PTR_DE = 2'h1;
   localparam logic [1:0] PTR_DL = 2'h2;
   localparam logic [2:0] STEP_L = 3'h0;
   localparam logic [2:0] STEP_H = 3'h1;
   localparam logic [2:0] STEP_E = 3'h2;
   localparam logic [2:0] STEP_D = 3'h3;
   localparam logic [2:0] STEP_HL = 3'h4;
   localparam logic [2:0] STEP_DE = 3'h5;
   localparam logic [11:0] FWIN_CTL_LO = 12'hfb0;
   localparam logic [11:0] FWIN_CTL_HI = 12'hfbf;
   localparam logic [11:0] FWIN_PORT_LO = 12'hff0;
   localparam logic [11:0] PWIN_LO = 12'hfc0;
   localparam logic [3:0] IO_BANK = 4'hf;
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STAT = 8'h04;
   localparam logic [7:0] ADR_SUPP = 8'h08;
   localparam logic [7:0] ADR_BANK = 8'h0c;
   localparam logic CTRL_STR_RST = 1'b1;
   localparam logic [4:0] BANK_RST = 5'h00;
   typedef enum logic [1:0] {K_PLAIN, K_TABLE, K_STR} kind_t;
   typedef enum logic [1:0] {GRP_NONE, GRP_A, GRP_B} group_t;
   typedef enum logic [1:0] {BM_F, BM_P, BM_H} bmode_t;
   typedef enum logic [2:0] {B_SET, B_CLR, B_TEST, B_TOCY, B_FROMCY, B_AND, B_OR, B_XOR} bitop_t;
   typedef struct packed {
      kind_t kind;
      group_t grp;
      logic [1:0] len;
      logic [6:0] taddr;
   } insn_t;
   typedef struct packed {
      logic adv;
      logic run;
      logic [1:0] step;
      logic [1:0] skip_cyc;
   } disp_t;
endpackage : seq_pkg

//--- core/table_indirect_exec_and_skip_logic.sv
// Purpose: Sequencing of the table-indirect instruction, skips and string effect.
// Assumes: The fetch unit waits while BUSY and reports DONE before the next fetch.
// Notes: Bit addressing and base adjustment are small registered helpers.
// How it works
// [RL1] Table-indirect fetches a two-byte entry from table area 0020H to 007FH.
// [RL2] Entries sit at even addresses only, at most 48; operand must be even.
// [RL3] A call entry calls a target within 0000H to 3FFFH.
// [RL4] A branch entry jumps to its target within the lower 16 KB.
// [RL5] Any two-byte entry runs in line except long branch and far call.
// [RL6] Software places only two-machine-cycle two-byte instructions in entries.
// [RL7] Paired one-byte entries: pointer access then step of that same pointer.
// [RL8] Software never puts upper-space branch or call targets in entries.
// [RL9] PC does not advance while the referenced instruction runs.
// [RL10] A pending skip skips the table-indirect like any one-byte instruction.
// [RL11] A met skip in the referenced instruction skips the following instruction.
// [RL12] A same-group string load before does not suppress the referenced one.
// [RL13] The referenced string load suppresses same-group instructions after it.
// [RL14] In a same-group string run only the first executes, others are NOP.
// [RL15] Group A is 4-bit and 8-bit immediate A loads; group B is HL load.
// [RL16] Bit set, clear, test, transfer, AND, OR and XOR are provided.
// [RL17] Short bit form reaches FB0H-FBFH and FF0H-FFFH; L-indexed form FC0H-FFFH.
// [RL18] H-relative bit form reaches the bank given by enable times select.
// [RL19] Base-m addition gives a base-m digit and carry on overflow.
// [RL20] Base-m subtraction gives the complement digit and carry on underflow.
// [RL21] Software never relies on the skip of the final add-m step.
// [RL22] Table operands span 20H-7FH with bit 0 clear.
// [RL23] Short branch targets reach at most 3F7FH.
// [RL24] A skipped table-indirect costs one cycle; three-byte skips cost two.
// [RL25] Skipped or suppressed instructions change nothing but still advance PC.
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/100ps
module table_indirect_exec_and_skip_logic import seq_pkg::*; (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_B,
   // Wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // Instruction stream
   input wire logic FETCH_VALID,
   input wire insn_t FETCH,
   input wire logic DONE_VALID,
   input wire logic DONE_SKIP,
   input wire group_t DONE_GRP,
   output disp_t DISP,
   output logic BUSY,
   // Table read port
   output logic TBL_REQ,
   output logic [6:0] TBL_ADDR,
   input wire logic TBL_ACK,
   input wire logic [15:0] TBL_DATA,
   // Referenced execution and control transfer
   output logic EXEC_VALID,
   output logic [15:0] EXEC_CODE,
   output logic JUMP,
   output logic CALL,
   output logic [13:0] TARGET,
   // Bit manipulation
   input wire logic BIT_REQ,
   input wire bmode_t BIT_MODE,
   input wire bitop_t BIT_OP,
   input wire logic [11:0] BIT_ADDR,
   input wire logic [1:0] BIT_SEL,
   input wire logic [3:0] REG_H,
   input wire logic [3:0] REG_L,
   input wire logic BIT_VAL,
   input wire logic CARRY_IN,
   output logic BIT_DONE,
   output logic BIT_OK,
   output logic [11:0] BIT_EADDR,
   output logic [1:0] BIT_EBIT,
   output logic BIT_RES,
   output logic BIT_CARRY,
   output logic BIT_SKIP,
   // Base adjustment
   input wire logic ADJ_REQ,
   input wire logic ADJ_SUB,
   input wire logic [3:0] ADJ_M,
   input wire logic [3:0] ADJ_A,
   input wire logic [3:0] ADJ_MEM,
   output logic ADJ_DONE,
   output logic [3:0] ADJ_RES,
   output logic ADJ_CARRY
);
   typedef enum logic [1:0] {S_IDLE, S_TFETCH, S_TEXEC} state_t;

   function automatic logic taddr_ok(input logic [6:0] a);
      return a >= TADDR_LO && !a[0];
   endfunction : taddr_ok

   function automatic logic entry_ok(input logic [15:0] e);
      logic ok;
      ok = 1'b0;
      case (e[15:14])
         ENT_BRANCH: ok = e[13:0] <= SHORT_TOP;
         ENT_CALL: ok = 1'b1;
         ENT_WORD: ok = e[13:8] != OP_LONG_BRANCH && e[13:8] != OP_FAR_CALL;
         default: begin
            case (e[9:8])
               PTR_HL: ok = e[2:0] == STEP_L || e[2:0] == STEP_H || e[2:0] == STEP_HL;
               PTR_DE: ok = e[2:0] == STEP_E || e[2:0] == STEP_D || e[2:0] == STEP_DE;
               PTR_DL: ok = e[2:0] == STEP_L || e[2:0] == STEP_D;
               default: ok = 1'b0;
            endcase
            ok = ok && e[15:12] == OP_PAIR_MEM && e[7:4] == OP_PAIR_STEP && e[11:10] != MEM_BAD
               && (e[11:10] != MEM_STORE || e[9:8] == PTR_HL);
         end
      endcase
      return ok;
   endfunction : entry_ok

   // Functional form of the adjust sequences; returns {carry, digit}.
   function automatic logic [4:0] base_adj(input logic sub, input logic [3:0] m, input logic [3:0] a,
                                           input logic [3:0] mem, input logic carry);
      logic [4:0] s;
      s = '0;
      if (!sub) begin
         s = {1'b0, a} + {1'b0, mem} + {4'h0, carry};
         if (s >= {1'b0, m})
            return {1'b1, 4'(s - {1'b0, m})};
         return {1'b0, s[3:0]};
      end
      s = {1'b0, a} - {1'b0, mem} - {4'h0, carry};
      if (s[4])
         return {1'b1, 4'(s[3:0] + m)};
      return {1'b0, s[3:0]};
   endfunction : base_adj

   logic rst_s1_reg;
   logic rst_n_reg;
   state_t state_reg;
   logic skip_reg;
   group_t last_grp_reg;
   logic str_en_reg;
   logic [4:0] bank_reg;
   logic [1:0] err_reg;
   logic [15:0] supp_reg;
   logic wb_hit;
   logic wb_wr;
   logic fetch_go;
   logic str_hit;
   logic [1:0] err_set;
   logic [1:0] err_clr;
   logic [31:0] rd_next;
   logic [11:0] bit_ea_next;
   logic bit_ok_next;
   logic [1:0] bit_idx_next;
   logic bit_res_next;
   logic bit_carry_next;
   logic [3:0] mb;

   // Release is synchronised so no flop leaves reset on a different edge.
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_s1_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n_reg <= rst_s1_reg;
      end
   end

   assign fetch_go = FETCH_VALID && state_reg == S_IDLE;
   assign str_hit = FETCH.kind == K_STR && FETCH.grp != GRP_NONE && str_en_reg
      && last_grp_reg == FETCH.grp; // RL14 RL15
   assign err_set[0] = fetch_go && !skip_reg && FETCH.kind == K_TABLE && !taddr_ok(FETCH.taddr); // RL22
   assign err_set[1] = state_reg == S_TFETCH && TBL_ACK && !entry_ok(TBL_DATA); // RL5 RL7
   assign wb_hit = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   assign wb_wr = wb_hit && WB_WE_I && WB_SEL_I[0];
   assign err_clr = (wb_wr && WB_ADR_I == ADR_STAT) ? WB_DAT_I[1:0] : 2'h0;

   always_comb begin
      rd_next = '0;
      case (WB_ADR_I)
         ADR_CTRL: rd_next[0] = str_en_reg;
         ADR_STAT: rd_next[7:0] = {BUSY, last_grp_reg, skip_reg, state_reg, err_reg};
         ADR_SUPP: rd_next[15:0] = supp_reg;
         ADR_BANK: rd_next[4:0] = bank_reg;
         default: rd_next = '0;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= '0;
      end else begin
         WB_ACK_O <= wb_hit;
         WB_DAT_O <= (wb_hit && !WB_WE_I) ? rd_next : '0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         str_en_reg <= CTRL_STR_RST;
         bank_reg <= BANK_RST;
      end else if (wb_wr) begin
         if (WB_ADR_I == ADR_CTRL)
            str_en_reg <= WB_DAT_I[0];
         if (WB_ADR_I == ADR_BANK)
            bank_reg <= WB_DAT_I[4:0];
      end
   end

   // A fault in the same cycle as its clear stays visible.
   always_ff @(posedge CORE_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg)
         err_reg <= '0;
      else
         err_reg <= (err_reg & ~err_clr) | err_set;
   end

   always_ff @(posedge CORE_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg)
         supp_reg <= '0;
      else if (fetch_go && (skip_reg || (FETCH.kind != K_TABLE && str_hit)))
         supp_reg <= supp_reg + 16'h0001;
   end

   always_ff @(posedge CORE_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg)
         skip_reg <= 1'b0;
      else if (DONE_VALID && DONE_SKIP)
         skip_reg <= 1'b1; // RL11
      else if (fetch_go)
         skip_reg <= 1'b0;
   end

   always_ff @(posedge CORE_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         state_reg <= S_IDLE;
         last_grp_reg <= GRP_NONE;
         DISP <= '0;
         BUSY <= 1'b0;
         TBL_REQ <= 1'b0;
         TBL_ADDR <= '0;
         EXEC_VALID <= 1'b0;
         EXEC_CODE <= '0;
         JUMP <= 1'b0;
         CALL <= 1'b0;
         TARGET <= '0;
      end else begin
         DISP <= '0;
         EXEC_VALID <= 1'b0;
         JUMP <= 1'b0;
         CALL <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               if (FETCH_VALID) begin
                  DISP.step <= FETCH.len;
                  if (skip_reg) begin
                     DISP.adv <= 1'b1; // RL25
                     DISP.skip_cyc <= (FETCH.kind == K_TABLE || FETCH.len != 2'd3) ? 2'd1 : 2'd2; // RL10 RL24
                     last_grp_reg <= GRP_NONE;
                  end else if (FETCH.kind == K_TABLE) begin
                     last_grp_reg <= last_grp_reg;
                     if (taddr_ok(FETCH.taddr)) begin
                        TBL_REQ <= 1'b1; // RL1 RL2
                        TBL_ADDR <= FETCH.taddr;
                        BUSY <= 1'b1;
                        state_reg <= S_TFETCH;
                     end else begin
                        DISP.adv <= 1'b1;
                     end
                  end else begin
                     DISP.adv <= 1'b1;
                     DISP.run <= !str_hit; // RL14 RL25
                     last_grp_reg <= (FETCH.kind == K_STR) ? FETCH.grp : GRP_NONE;
                  end
               end
            end
            S_TFETCH: begin
               if (TBL_ACK) begin
                  TBL_REQ <= 1'b0;
                  if (!entry_ok(TBL_DATA)) begin
                     DISP.adv <= 1'b1;
                     DISP.step <= 2'd1;
                     BUSY <= 1'b0;
                     state_reg <= S_IDLE;
                  end else if (TBL_DATA[15:14] == ENT_BRANCH || TBL_DATA[15:14] == ENT_CALL) begin
                     JUMP <= TBL_DATA[15:14] == ENT_BRANCH; // RL4 RL23
                     CALL <= TBL_DATA[15:14] == ENT_CALL; // RL3
                     TARGET <= TBL_DATA[13:0];
                     last_grp_reg <= GRP_NONE;
                     BUSY <= 1'b0;
                     state_reg <= S_IDLE;
                  end else begin
                     // The referenced code always runs, even after a same-group load.
                     EXEC_VALID <= 1'b1; // RL5 RL12
                     EXEC_CODE <= TBL_DATA;
                     state_reg <= S_TEXEC;
                  end
               end
            end
            S_TEXEC: begin
               if (DONE_VALID) begin
                  DISP.adv <= 1'b1; // RL9
                  DISP.step <= 2'd1;
                  last_grp_reg <= DONE_GRP; // RL13
                  BUSY <= 1'b0;
                  state_reg <= S_IDLE;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   assign mb = bank_reg[4] ? bank_reg[3:0] : 4'h0; // RL18

   always_comb begin
      bit_ea_next = {IO_BANK, BIT_ADDR[7:0]};
      bit_idx_next = BIT_SEL;
      bit_ok_next = 1'b0;
      case (BIT_MODE)
         BM_F: bit_ok_next = (BIT_ADDR >= FWIN_CTL_LO && BIT_ADDR <= FWIN_CTL_HI)
            || BIT_ADDR >= FWIN_PORT_LO; // RL17
         BM_P: begin
            bit_ea_next = {IO_BANK, BIT_ADDR[7:2], REG_L[3:2]}; // RL17
            bit_idx_next = REG_L[1:0];
            bit_ok_next = BIT_ADDR >= PWIN_LO;
         end
         default: begin
            bit_ea_next = {mb, REG_H, BIT_ADDR[3:0]}; // RL18
            bit_ok_next = 1'b1;
         end
      endcase
      bit_res_next = BIT_VAL;
      bit_carry_next = CARRY_IN;
      case (BIT_OP)
         B_SET: bit_res_next = 1'b1; // RL16
         B_CLR: bit_res_next = 1'b0;
         B_TOCY: bit_carry_next = BIT_VAL;
         B_FROMCY: bit_res_next = CARRY_IN;
         B_AND: bit_carry_next = CARRY_IN & BIT_VAL;
         B_OR: bit_carry_next = CARRY_IN | BIT_VAL;
         B_XOR: bit_carry_next = CARRY_IN ^ BIT_VAL;
         default: bit_res_next = BIT_VAL;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         BIT_DONE <= 1'b0;
         BIT_OK <= 1'b0;
         BIT_EADDR <= '0;
         BIT_EBIT <= '0;
         BIT_RES <= 1'b0;
         BIT_CARRY <= 1'b0;
         BIT_SKIP <= 1'b0;
      end else begin
         BIT_DONE <= BIT_REQ;
         if (BIT_REQ) begin
            BIT_OK <= bit_ok_next;
            BIT_EADDR <= bit_ea_next;
            BIT_EBIT <= bit_idx_next;
            BIT_RES <= bit_res_next;
            BIT_CARRY <= bit_carry_next;
            BIT_SKIP <= BIT_OP == B_TEST && BIT_VAL;
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ADJ_DONE <= 1'b0;
         ADJ_RES <= '0;
         ADJ_CARRY <= 1'b0;
      end else begin
         ADJ_DONE <= ADJ_REQ;
         if (ADJ_REQ)
            {ADJ_CARRY, ADJ_RES} <= base_adj(ADJ_SUB, ADJ_M, ADJ_A, ADJ_MEM, CARRY_IN); // RL19 RL20
      end
   end

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!rst_n_reg);

   property p_tbl_addr;
      TBL_REQ |-> TBL_ADDR >= TADDR_LO && !TBL_ADDR[0] && BUSY;
   endproperty
   a_tbl_addr: assert property (p_tbl_addr) else $error("table address out of area"); // RL2

   property p_tbl_issue;
      fetch_go && !skip_reg && FETCH.kind == K_TABLE && taddr_ok(FETCH.taddr)
         |=> TBL_REQ && TBL_ADDR == $past(FETCH.taddr) && !DISP.adv;
   endproperty
   a_tbl_issue: assert property (p_tbl_issue) else $error("table fetch not issued"); // RL1

   property p_call;
      state_reg == S_TFETCH && TBL_ACK && TBL_DATA[15:14] == ENT_CALL
         |=> CALL && !JUMP && TARGET == $past(TBL_DATA[13:0]) && !BUSY;
   endproperty
   a_call: assert property (p_call) else $error("call entry not taken"); // RL3

   property p_jump;
      JUMP |-> TARGET <= SHORT_TOP && !CALL && !EXEC_VALID;
   endproperty
   a_jump: assert property (p_jump) else $error("branch target outside short range"); // RL4

   property p_excl;
      state_reg == S_TFETCH && TBL_ACK && TBL_DATA[15:14] == ENT_WORD
         && (TBL_DATA[13:8] == OP_LONG_BRANCH || TBL_DATA[13:8] == OP_FAR_CALL)
         |=> !EXEC_VALID && DISP.adv && err_reg[1];
   endproperty
   a_excl: assert property (p_excl) else $error("excluded form executed"); // RL5

   property p_hold;
      state_reg == S_TEXEC |-> !DISP.adv && BUSY;
   endproperty
   a_hold: assert property (p_hold) else $error("PC advanced during referenced run"); // RL9

   property p_skip_tbl;
      fetch_go && skip_reg && FETCH.kind == K_TABLE
         |=> DISP.adv && !DISP.run && DISP.skip_cyc == 2'd1 && !TBL_REQ ##1 !BUSY;
   endproperty
   a_skip_tbl: assert property (p_skip_tbl) else $error("table-indirect not skipped"); // RL10

   property p_ref_skip;
      state_reg == S_TEXEC && DONE_VALID && DONE_SKIP |=> skip_reg && state_reg == S_IDLE;
   endproperty
   a_ref_skip: assert property (p_ref_skip) else $error("referenced skip lost"); // RL11

   property p_ref_grp;
      state_reg == S_TEXEC && DONE_VALID |=> last_grp_reg == $past(DONE_GRP);
   endproperty
   a_ref_grp: assert property (p_ref_grp) else $error("referenced string effect lost"); // RL13

   property p_str_nop;
      fetch_go && !skip_reg && FETCH.kind == K_STR && FETCH.grp != GRP_NONE && str_en_reg
         && last_grp_reg == FETCH.grp |=> DISP.adv && !DISP.run && DISP.step == $past(FETCH.len);
   endproperty
   a_str_nop: assert property (p_str_nop) else $error("string run not suppressed"); // RL14

   c_branch: cover property (state_reg == S_TFETCH && TBL_ACK ##1 JUMP);
   c_exec: cover property (EXEC_VALID ##[1:20] DISP.adv);
   c_str: cover property (DISP.adv && !DISP.run && DISP.skip_cyc == 2'd0);
   c_skip3: cover property (DISP.skip_cyc == 2'd2);
endmodule : table_indirect_exec_and_skip_logic

//--- dv/table_indirect_exec_and_skip_logic_tb_top.sv
// Purpose: Self-checking bench for the table-indirect sequencer.
// Assumes: Inputs change by non-blocking assignment right after rising edges.
// Notes: Outputs are sampled 1 ns after the edge, once its updates have landed, except in wb, which reads ack and data on the edge itself.
`timescale 1ns/100ps
module table_indirect_exec_and_skip_logic_tb_top import seq_pkg::*; ;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, fv = 1'b0, dv = 1'b0, dskip = 1'b0, tack = 1'b0;
   logic breq = 1'b0, bval = 1'b0, carry_in = 1'b0, areq = 1'b0, asub = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0, reg_l = 4'h0, am = 4'h0, aa = 4'h0, amem = 4'h0, ares;
   logic [31:0] wdat = 32'h0, rdat, rq;
   logic ack, busy, tbl_req, exec_valid, jump, call, bit_done, bit_ok, bit_res, bit_carry, bit_skip, adj_done;
   logic adj_carry;
   insn_t ins = '0;
   group_t dgrp = GRP_NONE;
   bmode_t bmode = BM_F;
   bitop_t bop = B_SET;
   logic [11:0] baddr = 12'h000, beaddr;
   logic [1:0] bebit;
   logic [15:0] tdat = 16'h0000, ecode;
   logic [6:0] taddr;
   logic [13:0] target;
   logic [15:0] ent [6];
   logic ent_ok [6];
   disp_t disp;
   int errors = 0, check_count = 0, cycles = 0;
   // Result, carry and skip expected per bit operation with the bit at 1 and carry at 0.
   localparam logic [7:0] RES_EXP = 8'hed, CARRY_EXP = 8'hc8, SKIP_EXP = 8'h04;
   always #2.5 core_clk = ~core_clk;
   table_indirect_exec_and_skip_logic dut (.CORE_CLK(core_clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .FETCH_VALID(fv), .FETCH(ins), .DONE_VALID(dv), .DONE_SKIP(dskip), .DONE_GRP(dgrp), .DISP(disp),
      .BUSY(busy), .TBL_REQ(tbl_req), .TBL_ADDR(taddr), .TBL_ACK(tack), .TBL_DATA(tdat),
      .EXEC_VALID(exec_valid), .EXEC_CODE(ecode), .JUMP(jump), .CALL(call), .TARGET(target),
      .BIT_REQ(breq), .BIT_MODE(bmode), .BIT_OP(bop), .BIT_ADDR(baddr), .BIT_SEL(reg_l[1:0]), .REG_H(reg_l),
      .REG_L(reg_l), .BIT_VAL(bval), .CARRY_IN(carry_in), .BIT_DONE(bit_done), .BIT_OK(bit_ok),
      .BIT_EADDR(beaddr), .BIT_EBIT(bebit), .BIT_RES(bit_res), .BIT_CARRY(bit_carry), .BIT_SKIP(bit_skip),
      .ADJ_REQ(areq), .ADJ_SUB(asub), .ADJ_M(am), .ADJ_A(aa), .ADJ_MEM(amem), .ADJ_DONE(adj_done),
      .ADJ_RES(ares), .ADJ_CARRY(adj_carry));
   task end_sim;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   // A hang in any handshake wait ends here instead of running forever.
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         end_sim();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      do @(posedge core_clk); while (ack !== 1'b1);
      rq = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task fetch(input kind_t k, input group_t g, input logic [1:0] len, input logic [6:0] ta);
      @(posedge core_clk);
      ins <= '{k, g, len, ta};
      fv <= 1'b1;
      @(posedge core_clk);
      fv <= 1'b0;
      #1;
   endtask : fetch
   task table_ack(input logic [15:0] d);
      @(posedge core_clk);
      tack <= 1'b1;
      tdat <= d;
      @(posedge core_clk);
      tack <= 1'b0;
      #1;
   endtask : table_ack
   task done(input logic s, input group_t g);
      @(posedge core_clk);
      dv <= 1'b1;
      dskip <= s;
      dgrp <= g;
      @(posedge core_clk);
      dv <= 1'b0;
      dskip <= 1'b0;
      #1;
   endtask : done
   task bitop(input bmode_t m, input bitop_t o, input logic [11:0] a, input logic [3:0] l, input logic v);
      @(posedge core_clk);
      breq <= 1'b1;
      bmode <= m;
      bop <= o;
      baddr <= a;
      reg_l <= l;
      bval <= v;
      @(posedge core_clk);
      breq <= 1'b0;
      #1;
   endtask : bitop
   task adj(input logic s, input logic [3:0] m, a, mem, input logic c, input logic [3:0] res, input logic co);
      @(posedge core_clk);
      areq <= 1'b1;
      asub <= s;
      am <= m;
      aa <= a;
      amem <= mem;
      carry_in <= c;
      @(posedge core_clk);
      areq <= 1'b0;
      #1;
      chk(ares, res);
      chk({adj_done, adj_carry}, {1'b1, co});
   endtask : adj
   task t_regs;
      wb(1'b0, ADR_BANK, 32'h0);
      chk(rq, 32'h0);
      wb(1'b1, ADR_BANK, 32'h12);
      wb(1'b0, ADR_BANK, 32'h0);
      chk(rq, 32'h12);
      wb(1'b0, 8'h40, 32'h0);
      chk(rq, 32'h0);
      $display("test regs done");
   endtask : t_regs
   task t_branch;
      fetch(K_TABLE, GRP_NONE, 2'd1, 7'h22);
      chk({tbl_req, busy, taddr}, {2'b11, 7'h22});
      table_ack({ENT_BRANCH, 14'h0123});
      chk({jump, call, target}, {2'b10, 14'h0123});
      fetch(K_TABLE, GRP_NONE, 2'd1, 7'h7e);
      table_ack({ENT_CALL, 14'h3f7f});
      chk({jump, call, target}, {2'b01, 14'h3f7f});
      fetch(K_TABLE, GRP_NONE, 2'd1, 7'h23);
      chk({disp.adv, disp.run, disp.step, tbl_req}, {2'b10, 2'd1, 1'b0});
      fetch(K_TABLE, GRP_NONE, 2'd1, 7'h1e);
      chk({disp.adv, tbl_req}, 2'b10);
      fetch(K_TABLE, GRP_NONE, 2'd1, 7'h20);
      table_ack({ENT_BRANCH, 14'h3f80});
      chk({jump, disp.adv, disp.step}, {2'b01, 2'd1});
      wb(1'b0, ADR_STAT, 32'h0);
      chk(rq[1:0], 2'b11);
      wb(1'b1, ADR_STAT, 32'h3);
      wb(1'b0, ADR_STAT, 32'h0);
      chk(rq[1:0], 2'b00);
      $display("test branch done");
   endtask : t_branch
   task t_entries;
      ent = '{{ENT_WORD, 6'h10, 8'h5a}, {OP_PAIR_MEM, 2'h0, PTR_DE, OP_PAIR_STEP, 1'b0, STEP_E},
             {ENT_WORD, OP_LONG_BRANCH, 8'h00}, {ENT_WORD, OP_FAR_CALL, 8'h00},
             {OP_PAIR_MEM, 2'h0, PTR_DE, OP_PAIR_STEP, 1'b0, STEP_H}, {OP_PAIR_MEM, MEM_STORE, PTR_DE, 8'h52}};
      ent_ok = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      for (int i = 0; i < 6; i++) begin
         fetch(K_TABLE, GRP_NONE, 2'd1, 7'h24);
         table_ack(ent[i]);
         chk({exec_valid, jump, call}, {ent_ok[i], 2'b00});
         if (ent_ok[i]) begin
            chk({ecode, busy}, {ent[i], 1'b1});
            done(i == 0, GRP_NONE);
            chk({disp, busy}, {1'b1, 1'b0, 2'd1, 2'd0, 1'b0});
         end
         if (i == 0) begin
            fetch(K_PLAIN, GRP_NONE, 2'd2, 7'h00);
            chk(disp, {1'b1, 1'b0, 2'd2, 2'd1});
         end
      end
      $display("test entries done");
   endtask : t_entries
   task t_skip;
      done(1'b1, GRP_NONE);
      fetch(K_TABLE, GRP_NONE, 2'd1, 7'h22);
      chk({disp, tbl_req, busy}, {1'b1, 1'b0, 2'd1, 2'd1, 2'b00});
      done(1'b1, GRP_NONE);
      fetch(K_PLAIN, GRP_NONE, 2'd3, 7'h00);
      chk(disp, {1'b1, 1'b0, 2'd3, 2'd2});
      $display("test skip done");
   endtask : t_skip
   task t_string;
      fetch(K_STR, GRP_A, 2'd1, 7'h00);
      chk(disp, {1'b1, 1'b1, 2'd1, 2'd0});
      done(1'b0, GRP_A);
      fetch(K_STR, GRP_A, 2'd2, 7'h00);
      chk(disp, {1'b1, 1'b0, 2'd2, 2'd0});
      fetch(K_STR, GRP_B, 2'd2, 7'h00);
      chk(disp, {1'b1, 1'b1, 2'd2, 2'd0});
      done(1'b0, GRP_B);
      fetch(K_TABLE, GRP_NONE, 2'd1, 7'h26);
      table_ack({ENT_WORD, 6'h11, 8'h34});
      chk(exec_valid, 1'b1);
      done(1'b0, GRP_B);
      fetch(K_STR, GRP_B, 2'd2, 7'h00);
      chk(disp, {1'b1, 1'b0, 2'd2, 2'd0});
      wb(1'b0, ADR_SUPP, 32'h0);
      chk(rq, 32'h5);
      wb(1'b1, ADR_CTRL, 32'h0);
      fetch(K_STR, GRP_B, 2'd2, 7'h00);
      chk(disp, {1'b1, 1'b1, 2'd2, 2'd0});
      $display("test string done");
   endtask : t_string
   task t_bits;
      for (int o = 0; o < 8; o++) begin
         bitop(BM_F, bitop_t'(o), 12'hfb5, 4'h2, 1'b1);
         chk({bit_done, bit_ok, beaddr, bebit}, {2'b11, 12'hfb5, 2'h2});
         chk({bit_res, bit_carry, bit_skip}, {RES_EXP[o], CARRY_EXP[o], SKIP_EXP[o]});
      end
      bitop(BM_F, B_TEST, 12'hff3, 4'h0, 1'b1);
      chk({bit_ok, bit_skip}, 2'b11);
      bitop(BM_F, B_SET, 12'hf40, 4'h0, 1'b0);
      chk(bit_ok, 1'b0);
      bitop(BM_P, B_CLR, 12'hfc0, 4'h6, 1'b0);
      chk({bit_ok, beaddr, bebit}, {1'b1, 12'hfc1, 2'h2});
      bitop(BM_H, B_SET, 12'h035, 4'h3, 1'b0);
      chk({bit_ok, beaddr, bebit}, {1'b1, 12'h235, 2'h3});
      adj(1'b0, 4'ha, 4'h9, 4'h5, 1'b0, 4'h4, 1'b1);
      adj(1'b0, 4'ha, 4'h2, 4'h3, 1'b1, 4'h6, 1'b0);
      adj(1'b1, 4'ha, 4'h3, 4'h5, 1'b0, 4'h8, 1'b1);
      adj(1'b1, 4'ha, 4'h7, 4'h2, 1'b0, 4'h5, 1'b0);
      $display("test bits done");
   endtask : t_bits
   initial begin
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_regs();
      t_branch();
      t_entries();
      t_skip();
      t_string();
      t_bits();
      end_sim();
   end
endmodule : table_indirect_exec_and_skip_logic_tb_top
